// ===== rtl/sadc_dev.sv
// Converter end: address capture, successive approximation and result shifting
//
// The register addresses and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module sadc_dev #(
    parameter int MUX_BITS = sadc_pkg::SADC_MUX_BITS,
    parameter bit HAS_SE = sadc_pkg::SADC_HAS_SE
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Serial link
    sadc_link_if.dev link,
    // Input levels as codes, one per channel
    input wire logic [sadc_pkg::SADC_RES_BITS-1:0] chan_level [sadc_pkg::SADC_NUM_CH],
    // Last completed result
    output logic [sadc_pkg::SADC_RES_BITS-1:0] result_out
);
    import sadc_pkg::*;

    typedef struct packed {
        logic [1:0] cs_s;
        logic [1:0] sclk_s;
        logic [1:0] di_s;
        logic [1:0] se_s;
        logic sclk_d;
        sadc_dev_state_t st;
        logic [3:0] cnt;
        logic [3:0] mux;
        logic [SADC_RES_BITS-1:0] sar;
        logic [SADC_RES_BITS-1:0] res;
        logic [SADC_RES_BITS-1:0] last;
        logic dout;
        logic oe_n;
        logic busy;
    } sadc_dev_reg_t;

    localparam sadc_dev_reg_t DEV_RST = '{
        cs_s: 2'h3, se_s: 2'h3, st: SADC_DEV_IDLE, oe_n: 1'b1, default: '0
    };
    localparam logic [3:0] LAST_ADDR = 4'(MUX_BITS - 1);
    localparam logic [3:0] LAST_BIT = 4'(SADC_RES_BITS - 1);
    localparam logic [3:0] TAIL_END = 4'(SADC_RES_BITS);

    sadc_dev_reg_t r_reg;
    sadc_dev_reg_t r_next;
    logic rise;
    logic fall;
    logic [3:0] mux_al;
    logic [2:0] pos_ch;
    logic [2:0] neg_ch;
    logic [SADC_RES_BITS-1:0] vin;

    assign rise = r_reg.sclk_s[1] && !r_reg.sclk_d;
    assign fall = !r_reg.sclk_s[1] && r_reg.sclk_d;

    // Selected input level; unaddressed variant sees pair 0, fixed polarity
    always_comb
    begin
        mux_al = 4'(r_reg.mux << (4 - MUX_BITS));
        pos_ch = {mux_al[1:0], mux_al[2]};
        neg_ch = {mux_al[1:0], !mux_al[2]};
        if (mux_al[3])
        begin
            vin = chan_level[pos_ch];
        end
        else if (chan_level[pos_ch] > chan_level[neg_ch])
        begin
            vin = chan_level[pos_ch] - chan_level[neg_ch];
        end
        else
        begin
            vin = '0;
        end
    end

    always_comb
    begin
        logic [SADC_RES_BITS-1:0] trial;
        logic [SADC_RES_BITS-1:0] sar_new;
        logic dec;
        trial = r_reg.sar | (8'h80 >> r_reg.cnt[2:0]);
        dec = vin > trial;
        sar_new = dec ? trial : r_reg.sar;
        r_next = r_reg;
        r_next.cs_s = {r_reg.cs_s[0], link.cs_n};
        r_next.sclk_s = {r_reg.sclk_s[0], link.sclk};
        r_next.di_s = {r_reg.di_s[0], link.serial_in_line};
        r_next.se_s = {r_reg.se_s[0], link.lsb_first_shift_enable_n};
        r_next.sclk_d = r_reg.sclk_s[1];
        if (r_reg.cs_s[1])
        begin
            // Select high wipes the whole sequence and releases the pin
            r_next.st = SADC_DEV_IDLE;
            r_next.cnt = '0;
            r_next.mux = '0;
            r_next.sar = '0;
            r_next.res = '0;
            r_next.dout = 1'b0;
            r_next.oe_n = 1'b1;
            r_next.busy = 1'b0;
        end
        else
        begin
            case (r_reg.st)
                SADC_DEV_IDLE:
                begin
                    if (rise && r_reg.di_s[1])
                    begin
                        if (MUX_BITS == 0)
                        begin
                            r_next.st = SADC_DEV_SETTLE;
                            r_next.busy = 1'b1;
                        end
                        else
                        begin
                            r_next.st = SADC_DEV_ADDR;
                            r_next.cnt = '0;
                        end
                    end
                end
                SADC_DEV_ADDR:
                begin
                    if (rise)
                    begin
                        r_next.mux = {r_reg.mux[2:0], r_reg.di_s[1]};
                        r_next.cnt = r_reg.cnt + 4'h1;
                        if (r_reg.cnt == LAST_ADDR)
                        begin
                            r_next.st = SADC_DEV_SETTLE;
                            r_next.busy = 1'b1;
                        end
                    end
                end
                SADC_DEV_SETTLE:
                begin
                    // Data-in is no longer looked at from here on
                    if (fall)
                    begin
                        r_next.oe_n = 1'b0;
                        r_next.dout = 1'b0;
                        r_next.st = SADC_DEV_CONV;
                        r_next.cnt = '0;
                    end
                end
                SADC_DEV_CONV:
                begin
                    if (fall)
                    begin
                        r_next.sar = sar_new;
                        r_next.dout = dec;
                        r_next.cnt = r_reg.cnt + 4'h1;
                        if (r_reg.cnt == LAST_BIT)
                        begin
                            r_next.res = sar_new;
                            r_next.st = SADC_DEV_ENDC;
                        end
                    end
                end
                SADC_DEV_ENDC:
                begin
                    if (rise)
                    begin
                        r_next.busy = 1'b0;
                        r_next.last = r_reg.res;
                        r_next.st = SADC_DEV_TAIL;
                        r_next.cnt = 4'h1;
                    end
                end
                SADC_DEV_TAIL:
                begin
                    if (fall)
                    begin
                        if (MUX_BITS == 0 || r_reg.cnt == TAIL_END)
                        begin
                            r_next.dout = 1'b0;
                            r_next.st = SADC_DEV_LOW;
                        end
                        else if (!(HAS_SE && r_reg.se_s[1]))
                        begin
                            r_next.dout = r_reg.res[r_reg.cnt[2:0]];
                            r_next.cnt = r_reg.cnt + 4'h1;
                        end
                    end
                end
                SADC_DEV_LOW:
                begin
                    r_next.dout = 1'b0;
                end
                default:
                begin
                    r_next.st = SADC_DEV_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r_reg <= DEV_RST;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign link.dout = r_reg.dout;
    assign link.dout_oe_n = r_reg.oe_n;
    assign link.conversion_in_progress_flag = r_reg.busy;
    assign result_out = r_reg.last;

endmodule
`default_nettype wire

// ===== rtl/sadc_pkg.sv
// Shared constants and types for the serial converter link
package sadc_pkg;

    localparam int SADC_RES_BITS = 8;
    localparam int SADC_MUX_BITS = 4;
    localparam int SADC_NUM_CH = 8;
    localparam bit SADC_HAS_SE = 1'b1;

    localparam int SADC_HCLK_NS = 100;
    localparam int SADC_LINK_NS = 800;
    localparam int SADC_HALF_CYC = SADC_LINK_NS / (2 * SADC_HCLK_NS);

    localparam logic [3:0] SADC_CTRL_OFS = 4'h0;
    localparam logic [3:0] SADC_STAT_OFS = 4'h4;
    localparam logic [3:0] SADC_RES_OFS = 4'h8;

    localparam int SADC_CTRL_GO = 0;
    localparam int SADC_CTRL_LSB = 1;
    localparam int SADC_CTRL_MUX = 8;
    localparam int SADC_STAT_BUSY = 0;
    localparam int SADC_STAT_DONE = 1;
    localparam int SADC_STAT_CONV = 2;
    localparam int SADC_RES_LSB = 8;

    typedef enum logic [2:0] {
        SADC_DEV_IDLE,
        SADC_DEV_ADDR,
        SADC_DEV_SETTLE,
        SADC_DEV_CONV,
        SADC_DEV_ENDC,
        SADC_DEV_TAIL,
        SADC_DEV_LOW
    } sadc_dev_state_t;

    typedef enum logic [1:0] {
        SADC_HOST_IDLE,
        SADC_HOST_RUN,
        SADC_HOST_GAP
    } sadc_host_state_t;

endpackage

// ===== rtl/sadc_link_if.sv
// Serial link between the converter end and the controlling host
`timescale 1ns/100ps
`default_nettype none
interface sadc_link_if #(
    parameter bit TIED = 1'b0
);
    logic cs_n;
    logic sclk;
    logic di_drv;
    logic di_oe_n;
    logic lsb_first_shift_enable_n;
    logic dout;
    logic dout_oe_n;
    logic conversion_in_progress_flag;
    logic serial_in_line;
    logic serial_out_line;

    // Undriven wire floats high; TIED joins both lines into one wire
    assign serial_in_line = !di_oe_n ? di_drv : ((TIED && !dout_oe_n) ? dout : 1'b1);
    assign serial_out_line = !dout_oe_n ? dout : ((TIED && !di_oe_n) ? di_drv : 1'b1);

    modport dev (
        input cs_n, sclk, serial_in_line, lsb_first_shift_enable_n,
        output dout, dout_oe_n, conversion_in_progress_flag
    );
    modport host (
        output cs_n, sclk, di_drv, di_oe_n, lsb_first_shift_enable_n,
        input serial_out_line, conversion_in_progress_flag
    );
endinterface
`default_nettype wire

// ===== rtl/sadc_host.sv
// Host end: AHB-Lite registers, serial clock generation and result capture
`timescale 1ns/100ps
`default_nettype none
module sadc_host #(
    parameter int MUX_BITS = sadc_pkg::SADC_MUX_BITS,
    parameter bit HAS_SE = sadc_pkg::SADC_HAS_SE,
    parameter int HALF_CYC = sadc_pkg::SADC_HALF_CYC
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Serial link
    sadc_link_if.host link
);
    import sadc_pkg::*;

    typedef struct packed {
        logic [1:0] do_s;
        logic [1:0] cv_s;
        sadc_host_state_t st;
        logic [7:0] ph;
        logic [4:0] tick;
        logic cs_n;
        logic sclk;
        logic di;
        logic di_oe_n;
        logic se_n;
        logic [3:0] mux;
        logic lsb_en;
        logic done;
        logic [SADC_RES_BITS-1:0] msb;
        logic [SADC_RES_BITS-1:0] lsb;
        logic ap_wr;
        logic [3:0] ap_addr;
        logic [31:0] rdata;
    } sadc_host_reg_t;

    localparam sadc_host_reg_t HOST_RST = '{
        st: SADC_HOST_IDLE, cs_n: 1'b1, di_oe_n: 1'b1, se_n: 1'b1, default: '0
    };
    localparam logic [7:0] PH_END = 8'(HALF_CYC - 1);
    localparam logic [4:0] T_MSB0 = 5'(MUX_BITS + 2);
    localparam logic [4:0] T_LSB0 = 5'(MUX_BITS + 9);
    localparam logic [4:0] T_LSBL = 5'(MUX_BITS + 16);

    sadc_host_reg_t r_reg;
    sadc_host_reg_t r_next;

    always_comb
    begin
        int idx;
        logic [4:0] t_last;
        idx = 0;
        t_last = r_reg.lsb_en ? T_LSBL : T_LSB0;
        r_next = r_reg;
        r_next.do_s = {r_reg.do_s[0], link.serial_out_line};
        r_next.cv_s = {r_reg.cv_s[0], link.conversion_in_progress_flag};
        // Bus address phase; read data is latched for the data phase
        r_next.ap_wr = 1'b0;
        if (hsel && htrans[1] && hready)
        begin
            r_next.ap_wr = hwrite;
            r_next.ap_addr = haddr[3:0];
            case (haddr[3:0])
                SADC_CTRL_OFS: r_next.rdata = 32'({r_reg.mux, 6'h0, r_reg.lsb_en, 1'b0});
                SADC_STAT_OFS: r_next.rdata = 32'({r_reg.cv_s[1], r_reg.done,
                    r_reg.st != SADC_HOST_IDLE});
                SADC_RES_OFS: r_next.rdata = 32'({r_reg.lsb, r_reg.msb});
                default: r_next.rdata = 32'h0;
            endcase
        end
        case (r_reg.st)
            SADC_HOST_IDLE:
            begin
                if (r_reg.ap_wr && r_reg.ap_addr == SADC_CTRL_OFS && hwdata[SADC_CTRL_GO])
                begin
                    // Select falls a half period before the first rising edge
                    r_next.st = SADC_HOST_RUN;
                    r_next.cs_n = 1'b0;
                    r_next.sclk = 1'b0;
                    r_next.ph = '0;
                    r_next.tick = '0;
                    r_next.di = 1'b1;
                    r_next.di_oe_n = 1'b0;
                    r_next.se_n = 1'b1;
                    r_next.mux = hwdata[SADC_CTRL_MUX +: 4];
                    r_next.lsb_en = hwdata[SADC_CTRL_LSB] && (MUX_BITS != 0);
                    r_next.done = 1'b0;
                    r_next.msb = '0;
                    r_next.lsb = '0;
                end
            end
            SADC_HOST_RUN:
            begin
                r_next.ph = r_reg.ph + 8'h1;
                if (r_reg.ph == PH_END)
                begin
                    r_next.ph = '0;
                    if (!r_reg.sclk)
                    begin
                        r_next.sclk = 1'b1;
                    end
                    else
                    begin
                        // Sample just before the falling edge that moves data-out
                        if (r_reg.tick >= T_MSB0 && r_reg.tick <= T_LSB0)
                        begin
                            r_next.msb = {r_reg.msb[6:0], r_reg.do_s[1]};
                        end
                        if (r_reg.lsb_en && r_reg.tick >= T_LSB0)
                        begin
                            r_next.lsb = {r_reg.do_s[1], r_reg.lsb[7:1]};
                        end
                        if (r_reg.tick == t_last)
                        begin
                            r_next.st = SADC_HOST_GAP;
                            r_next.cs_n = 1'b1;
                            r_next.sclk = 1'b0;
                            r_next.di_oe_n = 1'b1;
                            r_next.se_n = 1'b1;
                            r_next.done = 1'b1;
                        end
                        else
                        begin
                            r_next.sclk = 1'b0;
                            r_next.tick = r_reg.tick + 5'h1;
                            idx = MUX_BITS - int'(r_next.tick);
                            if (int'(r_next.tick) <= MUX_BITS)
                            begin
                                r_next.di = r_reg.mux[idx[1:0]];
                            end
                            else
                            begin
                                r_next.di = 1'b0;
                                r_next.di_oe_n = 1'b1;
                            end
                            if (HAS_SE && r_reg.lsb_en && r_next.tick == T_LSB0)
                            begin
                                r_next.se_n = 1'b0;
                            end
                        end
                    end
                end
            end
            SADC_HOST_GAP:
            begin
                r_next.ph = r_reg.ph + 8'h1;
                if (r_reg.ph == PH_END)
                begin
                    r_next.ph = '0;
                    r_next.st = SADC_HOST_IDLE;
                end
            end
            default:
            begin
                r_next.st = SADC_HOST_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r_reg <= HOST_RST;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = r_reg.rdata;
    assign link.cs_n = r_reg.cs_n;
    assign link.sclk = r_reg.sclk;
    assign link.di_drv = r_reg.di;
    assign link.di_oe_n = r_reg.di_oe_n;
    assign link.lsb_first_shift_enable_n = r_reg.se_n;

endmodule
`default_nettype wire

// ===== verif/sadc_link_chk.sv
// Concurrent checks on the serial link joining the host end and the converter end
`timescale 1ns/100ps
`default_nettype none
module sadc_link_chk #(
    parameter int HALF_CYC = 4
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Link signals
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic di_oe_n,
    input wire logic lsb_first_shift_enable_n,
    input wire logic dout,
    input wire logic dout_oe_n,
    input wire logic conversion_in_progress_flag
);
    // Busy spans nine link periods; one hclk slack for the pin synchronisers
    localparam int BUSY_LO = 18 * HALF_CYC - 1;
    localparam int BUSY_HI = 18 * HALF_CYC + 1;
    logic [7:0] busy_cnt_reg;
    logic [7:0] busy_cnt_next;

    always_comb
    begin
        busy_cnt_next = conversion_in_progress_flag ? busy_cnt_reg + 8'h01 : 8'h00;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            busy_cnt_reg <= 8'h00;
        else
            busy_cnt_reg <= busy_cnt_next;
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_idle_released: assert property (cs_n [*6] |-> dout_oe_n)
        else $error("data-out driven while select idle");
    chk_idle_clears: assert property (cs_n [*6] |-> !conversion_in_progress_flag)
        else $error("busy flag survives idle select");
    chk_no_clash: assert property (!dout_oe_n |-> di_oe_n)
        else $error("both ends drive the data line");
    chk_lead_zero: assert property ($fell(dout_oe_n) |-> !dout && conversion_in_progress_flag)
        else $error("first driven bit is not a busy leading zero");
    chk_settle_drive: assert property ($rose(conversion_in_progress_flag) |-> dout_oe_n ##[1:8] !dout_oe_n)
        else $error("data-out not driven after settling began");
    chk_shift_on_low: assert property (!cs_n && !dout_oe_n && $past(!dout_oe_n) && $changed(dout) |-> !sclk)
        else $error("data-out changed while link clock high");
    chk_busy_length: assert property ($fell(conversion_in_progress_flag) && !cs_n |-> busy_cnt_reg inside {[BUSY_LO:BUSY_HI]})
        else $error("busy length differs from nine link periods");
    chk_busy_select: assert property ($rose(conversion_in_progress_flag) |-> !cs_n && !$past(cs_n, 8))
        else $error("conversion began without select held low");
    chk_lsb_hold: assert property (!cs_n && !dout_oe_n && !conversion_in_progress_flag
        && $past(!conversion_in_progress_flag) && $changed(dout)
        |-> !$past(lsb_first_shift_enable_n, 3))
        else $error("least significant bit moved while enable held high");
endmodule
`default_nettype wire

// ===== verif/serial_adc_conversion_interface_tb_top.sv
// Self-checking bench joining host and converter ends over the serial link
`timescale 1ns/100ps
`default_nettype none
module serial_adc_conversion_interface_tb_top;
    import sadc_pkg::*;

    typedef struct packed {
        logic [3:0] mux;
        logic lsb;
        logic [7:0] code;
    } sadc_row_t;

    localparam int HC = 4;
    logic hclk;
    logic hresetn;
    logic hsel0;
    logic hsel1;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
    logic hro0;
    logic hro1;
    logic hresp0;
    logic hresp1;
    logic [31:0] hrdata0;
    logic [31:0] hrdata1;
    logic [31:0] rd_val;
    logic [7:0] res0;
    logic [7:0] res1;
    logic [15:0] cap [2];
    int ncap [2];
    int n_fail;
    int checked;
    logic [7:0] lvl0 [SADC_NUM_CH] = '{8'h00, 8'h01, 8'h80, 8'hff, 8'h55, 8'h02, 8'hc3, 8'h40};
    logic [7:0] lvl1 [SADC_NUM_CH] = '{8'h90, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    // Mux word, LSB-first request, expected code (strict compare gives level minus one, zero for level zero)
    sadc_row_t rows [10] = '{
        '{4'b1000, 1'b1, 8'h00}, '{4'b1100, 1'b0, 8'h00}, '{4'b1001, 1'b1, 8'h7f},
        '{4'b1101, 1'b0, 8'hfe}, '{4'b1010, 1'b1, 8'h54}, '{4'b1111, 1'b0, 8'h3f},
        '{4'b0001, 1'b1, 8'h00}, '{4'b0101, 1'b0, 8'h7e}, '{4'b0011, 1'b1, 8'h82},
        '{4'b0010, 1'b0, 8'h52}};

    sadc_link_if #(.TIED(1'b0)) link0 ();
    sadc_link_if #(.TIED(1'b1)) link1 ();
    assign hready = hro0 & hro1;

    sadc_host #(.HALF_CYC(HC)) u_sadc_host (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel0), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hro0),
        .hresp(hresp0), .hrdata(hrdata0), .link(link0.host));
    sadc_dev u_sadc_dev (
        .hclk(hclk), .hresetn(hresetn), .link(link0.dev), .chan_level(lvl0), .result_out(res0));
    // Fixed-input variant on one shared data wire
    sadc_host #(.MUX_BITS(0), .HAS_SE(1'b0), .HALF_CYC(HC)) u_sadc_host_1 (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hro1),
        .hresp(hresp1), .hrdata(hrdata1), .link(link1.host));
    sadc_dev #(.MUX_BITS(0), .HAS_SE(1'b0)) u_sadc_dev_1 (
        .hclk(hclk), .hresetn(hresetn), .link(link1.dev), .chan_level(lvl1), .result_out(res1));
    sadc_link_chk #(.HALF_CYC(HC)) u_sadc_link_chk (
        .hclk(hclk), .hresetn(hresetn), .cs_n(link0.cs_n), .sclk(link0.sclk),
        .di_oe_n(link0.di_oe_n), .lsb_first_shift_enable_n(link0.lsb_first_shift_enable_n),
        .dout(link0.dout), .dout_oe_n(link0.dout_oe_n),
        .conversion_in_progress_flag(link0.conversion_in_progress_flag));

    initial
    begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // Record driven data-out bits at each link clock rise, per frame
    always @(negedge link0.cs_n)
    begin
        cap[0] = 16'h0000;
        ncap[0] = 0;
    end
    always @(negedge link1.cs_n)
    begin
        cap[1] = 16'h0000;
        ncap[1] = 0;
    end
    always @(posedge link0.sclk)
    begin
        if (link0.dout_oe_n === 1'b0)
        begin
            if (ncap[0] < 16)
                cap[0][15 - ncap[0]] = link0.serial_out_line;
            ncap[0]++;
        end
    end
    always @(posedge link1.sclk)
    begin
        if (link1.dout_oe_n === 1'b0)
        begin
            if (ncap[1] < 16)
                cap[1][15 - ncap[1]] = link1.serial_out_line;
            ncap[1]++;
        end
    end

    task automatic finish_test;
        if (n_fail == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_wire(input int s, input logic [15:0] exp, input int n);
        checked++;
        if (cap[s] !== exp || ncap[s] != n)
        begin
            n_fail++;
            $display("Error at %0t: stream %h/%0d, expected %h/%0d", $time, cap[s], ncap[s], exp, n);
        end
    endtask

    task automatic ahb(input bit s, input logic [31:0] a, input bit w, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel0 <= !s;
        hsel1 <= s;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel0 <= 1'b0;
        hsel1 <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = s ? hrdata1 : hrdata0;
    endtask

    // One conversion; poke repeats go with another mux word while it runs
    task automatic run_conv(input bit s, input sadc_row_t r, input bit poke);
        logic [31:0] rd;
        int k;
        ahb(s, 32'h0, 1'b1, {20'h0, r.mux, 6'h0, r.lsb, 1'b1}, rd);
        if (poke)
        begin
            repeat (40) @(posedge hclk);
            ahb(s, 32'h0, 1'b1, {20'h0, ~r.mux, 6'h0, r.lsb, 1'b1}, rd);
        end
        rd = 32'h0;
        k = 0;
        while (rd[1] !== 1'b1 && k < 200)
        begin
            ahb(s, 32'h4, 1'b0, 32'h0, rd);
            k++;
        end
        // Host spends one half period in its gap before busy clears
        repeat (2 * HC) @(posedge hclk);
        ahb(s, 32'h4, 1'b0, 32'h0, rd);
        chk_reg(rd, 32'h2);
        ahb(s, 32'h8, 1'b0, 32'h0, rd);
        chk_reg(rd, {16'h0, r.lsb ? r.code : 8'h00, r.code});
        chk_reg({24'h0, s ? res1 : res0}, {24'h0, r.code});
        chk_wire(s, r.lsb ? {1'b0, r.code, r.code[1], r.code[2], r.code[3], r.code[4],
            r.code[5], r.code[6], r.code[7]} : {1'b0, r.code, 7'h00}, r.lsb ? 16 : 9);
        if (!s)
        begin
            ahb(s, 32'h0, 1'b0, 32'h0, rd);
            chk_reg(rd, {20'h0, r.mux, 6'h0, r.lsb, 1'b0});
        end
    endtask

    initial
    begin
        #2000000;
        n_fail++;
        $display("Error at %0t: run did not finish", $time);
        finish_test;
    end

    initial
    begin
        n_fail = 0;
        checked = 0;
        hresetn = 1'b0;
        hsel0 = 1'b0;
        hsel1 = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (3) @(posedge hclk);
        chk_reg({30'h0, link0.cs_n, link0.dout_oe_n}, 32'h3);
        hresetn <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            ahb(1'b0, 32'(4 * i), 1'b0, 32'h0, rd_val);
            chk_reg(rd_val, 32'h0);
        end
        foreach (rows[i])
            run_conv(1'b0, rows[i], 1'b0);
        run_conv(1'b0, rows[8], 1'b1);
        run_conv(1'b1, '{4'h0, 1'b0, 8'h7f}, 1'b0);
        // New negative level on the fixed pair gives a fresh result
        lvl1[1] <= 8'h30;
        run_conv(1'b1, '{4'h0, 1'b0, 8'h5f}, 1'b0);
        // Reset in mid-conversion, then a clean run
        ahb(1'b0, 32'h0, 1'b1, {20'h0, 4'b1001, 8'h03}, rd_val);
        repeat (60) @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk_reg({29'h0, link0.cs_n, link0.dout_oe_n, link0.conversion_in_progress_flag}, 32'h6);
        hresetn <= 1'b1;
        ahb(1'b0, 32'h4, 1'b0, 32'h0, rd_val);
        chk_reg(rd_val, 32'h0);
        run_conv(1'b0, rows[3], 1'b0);
        finish_test;
    end
endmodule
`default_nettype wire
